// file: ata_drive_model.sv
/* behavioural drive on the secondary channel.
   assumes pull-ups on data and ready, as on the cable. */
`timescale 1ns/1ns
`default_nettype none
module ata_drive_model
  import pci_ata_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire ata_ctl_t    ata_ctl,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic [15:0] rd_word,
  input  wire logic        slow,
  input  wire logic        load,
  input  wire logic [3:0]  words,
  output logic      [15:0] data_in,
  output logic             ready,
  output logic             dma_req
);
  logic       strobe;
  logic       strobe_q;
  logic [3:0] low_q;
  logic [3:0] left_q;
  assign strobe = !ata_ctl.sec_read_strobe_n || !ata_ctl.sec_write_strobe_n;
  // released bus floats to the pull-ups, never keeps stale data
  assign data_in = data_oe ? data_out : (!ata_ctl.sec_read_strobe_n ? rd_word : 16'hffff);
  assign dma_req = left_q != 4'h0;
  assign ready = !(slow && strobe && low_q < 4'h3);
  always_ff @(posedge clk_sys) begin
    strobe_q <= strobe;
    low_q <= strobe ? low_q + 4'h1 : 4'h0;
    // request drops at the last strobe start, seen before recovery ends
    if (load)
      left_q <= words;
    else if (strobe && !strobe_q && !ata_ctl.sec_dma_ack_n && dma_req)
      left_q <= left_q - 4'h1;
  end
endmodule
`default_nettype wire

// file: pci_ata_channel_interface.sv
/*
  pci target bridging i/o cycles to the secondary ata channel, answering config cycles itself, with
  multiword dma handshake, parity, error and interrupt pins.
  assumes clk_sys is the pci clock, rst is pci reset already aligned to it,
  and the pad ring resolves the _oe triples into wires.
*/
// Overview of operation
// RULE_01: channel data is a 16-bit two-way bus, low byte on bits 7..0.
// RULE_02: data bus floats by default, driven only during the write strobe pulse.
// RULE_03: while dma acknowledge is active both chip selects stay negated, 16-bit transfers.
// RULE_04: drive register address comes from ad bits 2..0 and the byte enables.
// RULE_05: read strobe active low to read, high when idle, timed by pio settings.
// RULE_06: write strobe active low to write, high when idle, timed by pio settings.
// RULE_07: cable detect low means 40-conductor, high means 80-conductor cable.
// RULE_08: dma acknowledge answers dma request when the bridge can move data.
// RULE_09: drive interrupt request is a source of the pci interrupt.
// RULE_10: drive ready is active high and stretches the strobe.
// RULE_11: the drive raises dma request when ready and handshakes with acknowledge.
// RULE_12: drive reset is a copy of pci reset, also asserted by software.
// RULE_13: first clock with frame asserted is the address phase.
// RULE_14: data lanes: bits 7..0 least significant byte, 31..24 most significant.
// RULE_15: a word moves only when irdy and trdy are both asserted.
// RULE_16: c/be carries the command at address, byte enables during data.
// RULE_17: idsel selects the device for configuration cycles.
// RULE_18: pci inputs are sampled on the rising clock edge.
// RULE_19: target drives devsel on its own decode and signals stop.
// RULE_20: target reports write data parity errors on perr.
// RULE_21: address parity error pulls serr low for exactly one clock.
// RULE_22: par is even parity over ad and c/be, one clock behind ad.
// RULE_23: inta stays low while the enabled drive interrupt request is high.
`timescale 1ns/1ns
`default_nettype none
module pci_ata_channel_interface
  import pci_ata_pkg::*;
#(
  parameter logic [31:0] CMD_BASE  = CMD_BASE_DEF,
  parameter logic [31:0] CTL_BASE  = CTL_BASE_DEF,
  parameter logic [15:0] VENDOR_ID = VENDOR_ID_DEF,
  parameter logic [15:0] DEVICE_ID = DEVICE_ID_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // pci side
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic        idsel,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_n,
  input  wire logic        par_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe,
  output logic             par_out,
  output logic             par_oe,
  output pci_tgt_t         tgt,
  output logic             tgt_oe,
  output logic             perr_n_out,
  output logic             perr_oe,
  output logic             serr_oe,
  output logic             inta_oe,
  // ata side
  input  wire logic [15:0] sec_disk_data_in,
  output logic      [15:0] sec_disk_data_out,
  output logic             sec_disk_data_oe,
  output ata_ctl_t         ata_ctl,
  output logic             sec_drive_reset_n,
  input  wire logic        sec_cable_type_in,
  input  wire logic        sec_drive_irq,
  input  wire logic        sec_drive_ready,
  input  wire logic        sec_dma_req,
  // user side
  input  wire logic        soft_reset,
  input  wire logic        irq_enable,
  input  wire logic        serr_enable,
  input  wire logic        parity_enable,
  input  wire logic [7:0]  pio_active,
  input  wire logic [7:0]  pio_recovery,
  input  wire logic        dma_enable,
  input  wire logic        dma_to_drive,
  input  wire logic [15:0] dma_wdata,
  input  wire logic        dma_wvalid,
  output logic             dma_wtaken,
  output logic      [15:0] dma_rdata,
  output logic             dma_rvalid,
  output logic             cable_80
);

  // pin synchronisers
  logic [19:0] pins_s;
  logic [15:0] dd_s;
  logic        cable_s;
  logic        irq_s;
  logic        ready_s;
  logic        dmarq_s;

  sync_bits #(.W(20)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({sec_disk_data_in, sec_cable_type_in, sec_drive_irq,
                sec_drive_ready, sec_dma_req}),
    .sync_out (pins_s)
  );

  assign dd_s    = pins_s[19:4];
  assign cable_s = pins_s[3];
  assign irq_s   = pins_s[2];
  assign ready_s = pins_s[1];
  assign dmarq_s = pins_s[0];

  // byte lane helpers
  function automatic logic [1:0] first_lane(input logic [3:0] be_n);
    logic [1:0] l;
    l = 2'd0;
    if (!be_n[0]) begin
      l = 2'd0;
    end else if (!be_n[1]) begin
      l = 2'd1;
    end else if (!be_n[2]) begin
      l = 2'd2;
    end else begin
      l = 2'd3;
    end
    return l;
  endfunction

  function automatic logic [15:0] lane_word(input logic [31:0] d, input logic [1:0] l);
    logic [15:0] w;
    w = WORD_ZERO;
    unique case (l)
      2'd0: w = d[15:0];
      2'd1: w = {8'h00, d[15:8]};
      2'd2: w = d[31:16];
      2'd3: w = {8'h00, d[31:24]};
    endcase
    return w;
  endfunction

  // bytes placed on every lane they could belong to
  function automatic logic [31:0] lane_place(input logic [15:0] dd, input logic [1:0] l);
    return l[0] ? {4{dd[7:0]}} : {2{dd}};
  endfunction

  // address phase detect and decode
  logic frame_prev_q;
  logic addr_phase;
  logic io_cmd;
  logic cfg_cmd;
  logic cmd_hit;
  logic ctl_hit;
  logic cfg_hit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_prev_q <= 1'b1;
    end else begin
      frame_prev_q <= frame_n; // RULE_18
    end
  end

  assign addr_phase = !frame_n && frame_prev_q; // RULE_13
  assign io_cmd     = (cbe_n == CMD_IO_RD) || (cbe_n == CMD_IO_WR); // RULE_16
  assign cfg_cmd    = (cbe_n == CMD_CFG_RD) || (cbe_n == CMD_CFG_WR);
  // i/o is byte-granular, config dword-granular
  assign cmd_hit    = io_cmd && (ad_in[31:3] == CMD_BASE[31:3]); // RULE_13
  assign ctl_hit    = io_cmd && (ad_in[31:2] == CTL_BASE[31:2]);
  assign cfg_hit    = cfg_cmd && idsel && (ad_in[1:0] == 2'b00); // RULE_17

  // transaction sequencer
  state_t      state_q;
  logic        is_write_q;
  logic        is_cfg_q;
  logic        is_ctl_q;
  logic        a2_q;
  logic [5:0]  cfg_idx_q;
  logic [3:0]  be_q;
  logic [31:0] rdata_q;
  logic [7:0]  cnt_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q           <= S_IDLE;
      is_write_q        <= 1'b0;
      is_cfg_q          <= 1'b0;
      is_ctl_q          <= 1'b0;
      a2_q              <= 1'b0;
      cfg_idx_q         <= CFG_IDX_ID;
      be_q              <= 4'hf;
      rdata_q           <= CFG_ZERO;
      cnt_q             <= CNT_ZERO;
      tgt               <= TGT_IDLE;
      tgt_oe            <= 1'b0;
      ad_oe             <= 1'b0;
      ata_ctl           <= ATA_IDLE;
      sec_disk_data_out <= WORD_ZERO;
      sec_disk_data_oe  <= 1'b0;
      dma_wtaken        <= 1'b0;
      dma_rdata         <= WORD_ZERO;
      dma_rvalid        <= 1'b0;
    end else begin
      dma_wtaken <= 1'b0;
      dma_rvalid <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          // pci access wins over a pending dma request
          if (addr_phase && (cmd_hit || ctl_hit || cfg_hit)) begin
            is_write_q   <= cbe_n[0];
            is_cfg_q     <= cfg_hit;
            is_ctl_q     <= ctl_hit && !cmd_hit;
            a2_q         <= ad_in[2];
            cfg_idx_q    <= ad_in[7:2];
            tgt_oe       <= 1'b1;
            tgt.devsel_n <= 1'b0; // RULE_19
            state_q      <= S_DEC;
          end else if (dma_enable && dmarq_s) begin // RULE_11
            ata_ctl.sec_dma_ack_n          <= 1'b0; // RULE_08
            ata_ctl.sec_cmd_block_select_n <= 1'b1; // RULE_03
            ata_ctl.sec_ctl_block_select_n <= 1'b1; // RULE_03
            ata_ctl.sec_disk_reg_addr      <= 3'b000;
            state_q                        <= S_DMA;
          end
        end
        S_DEC: begin
          be_q <= cbe_n; // RULE_16
          if (is_cfg_q) begin
            rdata_q    <= (cfg_idx_q == CFG_IDX_ID) ? {DEVICE_ID, VENDOR_ID} : CFG_ZERO;
            cnt_q      <= CNT_ZERO;
            state_q    <= S_RECOV;
          end else if (!is_write_q || !irdy_n) begin
            // writes wait for irdy: data and enables stable
            ata_ctl.sec_disk_reg_addr      <= {is_ctl_q | a2_q, first_lane(cbe_n)}; // RULE_04
            ata_ctl.sec_cmd_block_select_n <= is_ctl_q;
            ata_ctl.sec_ctl_block_select_n <= !is_ctl_q;
            if (is_write_q) begin
              sec_disk_data_out           <= lane_word(ad_in, first_lane(cbe_n)); // RULE_14
              sec_disk_data_oe            <= 1'b1; // RULE_02
              ata_ctl.sec_write_strobe_n  <= 1'b0; // RULE_06
            end else begin
              ata_ctl.sec_read_strobe_n   <= 1'b0; // RULE_05
            end
            cnt_q   <= pio_active;
            state_q <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (ready_s) begin // RULE_10
            ata_ctl.sec_read_strobe_n  <= 1'b1;
            ata_ctl.sec_write_strobe_n <= 1'b1;
            sec_disk_data_oe           <= 1'b0; // RULE_02
            rdata_q                    <= lane_place(dd_s, first_lane(be_q)); // RULE_01
            if (!ata_ctl.sec_dma_ack_n && !dma_to_drive) begin
              dma_rdata  <= dd_s; // RULE_03
              dma_rvalid <= 1'b1;
            end
            cnt_q   <= pio_recovery;
            state_q <= S_RECOV;
          end
        end
        S_RECOV: begin
          if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (!ata_ctl.sec_dma_ack_n) begin
            state_q <= S_DMA;
          end else begin
            ata_ctl.sec_cmd_block_select_n <= 1'b1;
            ata_ctl.sec_ctl_block_select_n <= 1'b1;
            ad_oe      <= !is_write_q;
            tgt.trdy_n <= 1'b0; // RULE_15
            tgt.stop_n <= 1'b0; // RULE_19
            state_q    <= S_RESP;
          end
        end
        S_RESP: begin
          // single data phase, then disconnect
          if (!irdy_n) begin // RULE_15
            tgt     <= TGT_IDLE;
            ad_oe   <= 1'b0;
            state_q <= S_TURN;
          end
        end
        S_TURN: begin
          // one clock driven high before release
          tgt_oe  <= 1'b0;
          state_q <= S_IDLE;
        end
        S_DMA: begin
          if (!dmarq_s) begin
            ata_ctl.sec_dma_ack_n <= 1'b1; // RULE_08
            state_q               <= S_IDLE;
          end else if (dma_to_drive) begin
            if (dma_wvalid) begin
              sec_disk_data_out          <= dma_wdata;
              sec_disk_data_oe           <= 1'b1; // RULE_02
              ata_ctl.sec_write_strobe_n <= 1'b0; // RULE_06
              dma_wtaken                 <= 1'b1;
              cnt_q                      <= pio_active;
              state_q                    <= S_STROBE;
            end
          end else begin
            ata_ctl.sec_read_strobe_n <= 1'b0; // RULE_05
            cnt_q                     <= pio_active;
            state_q                   <= S_STROBE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // read data onto ad, held while the data phase is open
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ad_out <= CFG_ZERO;
    end else begin
      ad_out <= rdata_q; // RULE_14
    end
  end

  // parity generation trails ad by one clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      par_out <= 1'b0;
      par_oe  <= 1'b0;
    end else begin
      par_out <= ^{ad_out, cbe_n}; // RULE_22
      par_oe  <= ad_oe; // RULE_22
    end
  end

  // address parity check, serr for one clock
  logic apar_chk_q;
  logic apar_exp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      apar_chk_q <= 1'b0;
      apar_exp_q <= 1'b0;
      serr_oe    <= 1'b0;
    end else begin
      apar_chk_q <= addr_phase && (cmd_hit || ctl_hit || cfg_hit);
      apar_exp_q <= ^{ad_in, cbe_n}; // RULE_22
      // a single pulse; the pull-up restores the line
      serr_oe    <= apar_chk_q && (par_in != apar_exp_q) && serr_enable; // RULE_21
    end
  end

  // write data parity check on the transfer clock
  logic dpar_chk_q;
  logic dpar_exp_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dpar_chk_q <= 1'b0;
      dpar_exp_q <= 1'b0;
      perr_n_out <= 1'b1;
      perr_oe    <= 1'b0;
    end else begin
      dpar_chk_q <= (state_q == S_RESP) && !irdy_n && is_write_q;
      dpar_exp_q <= ^{ad_in, cbe_n};
      perr_oe    <= dpar_chk_q;
      perr_n_out <= !(dpar_chk_q && (par_in != dpar_exp_q) && parity_enable); // RULE_20
    end
  end

  // interrupt, cable type and drive reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inta_oe <= 1'b0;
    end else begin
      inta_oe <= irq_s && irq_enable; // RULE_09 RULE_23
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cable_80 <= 1'b0;
    end else begin
      cable_80 <= cable_s; // RULE_07
    end
  end

  // reset held low through pci reset, plus software request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sec_drive_reset_n <= 1'b0;
    end else begin
      sec_drive_reset_n <= !soft_reset; // RULE_12
    end
  end

endmodule
`default_nettype wire

// file: pci_ata_channel_interface_properties.sv
/* port checker for the pci to ata bridge.
   assumes one pci clock and the synchronous high reset. */
`timescale 1ns/1ns
`default_nettype none
module pci_ata_channel_interface_properties
  import pci_ata_pkg::*;
#(
  parameter logic [31:0] CMD_BASE = CMD_BASE_DEF
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic [31:0] ad_in,
  input wire logic [3:0]  cbe_n,
  input wire logic [31:0] ad_out,
  input wire logic        ad_oe,
  input wire logic        par_out,
  input wire logic        par_oe,
  input wire pci_tgt_t    tgt,
  input wire logic        tgt_oe,
  input wire logic        perr_n_out,
  input wire logic        perr_oe,
  input wire logic        serr_oe,
  input wire logic        inta_oe,
  input wire logic        sec_disk_data_oe,
  input wire ata_ctl_t    ata_ctl,
  input wire logic        sec_drive_reset_n,
  input wire logic        sec_cable_type_in,
  input wire logic        sec_drive_irq,
  input wire logic        sec_dma_req,
  input wire logic        soft_reset,
  input wire logic        irq_enable,
  input wire logic        dma_enable,
  input wire logic        cable_80
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence io_claim;
    $past(frame_n) && !frame_n && cbe_n[3:1] == 3'h1 && ad_in[31:3] == CMD_BASE[31:3];
  endsequence
  sequence xfer;
    !irdy_n && !tgt.trdy_n && tgt_oe;
  endsequence
  sequence dma_ask;
    (dma_enable && sec_dma_req) [*4];
  endsequence
  claim_devsel_a: assert property (io_claim |=> !tgt.devsel_n && tgt_oe)
    else $error("io claim without devsel");
  xfer_release_a: assert property (xfer |=> tgt == TGT_IDLE && tgt_oe ##1 !tgt_oe)
    else $error("target not released");
  stop_with_trdy_a: assert property (!tgt.trdy_n && tgt_oe |-> !tgt.stop_n)
    else $error("trdy without stop");
  parity_late_a: assert property (ad_oe |=> par_oe && par_out == ^{$past(ad_out), $past(cbe_n)})
    else $error("parity wrong");
  serr_pulse_a: assert property (serr_oe |=> !serr_oe)
    else $error("serr held too long");
  perr_enable_a: assert property (!perr_n_out |-> perr_oe)
    else $error("perr low undriven");
  ack_no_select_a: assert property (!ata_ctl.sec_dma_ack_n |-> ata_ctl[7:6] == 2'h3)
    else $error("select during dma ack");
  data_oe_strobe_a: assert property (sec_disk_data_oe |-> !ata_ctl.sec_write_strobe_n)
    else $error("data driven off strobe");
  strobes_apart_a: assert property (ata_ctl.sec_read_strobe_n || ata_ctl.sec_write_strobe_n)
    else $error("both strobes low");
  dma_answer_a: assert property (dma_ask |-> ##[0:600] !ata_ctl.sec_dma_ack_n)
    else $error("dma not acknowledged");
  irq_raise_a: assert property ((sec_drive_irq && irq_enable) [*5] |-> inta_oe)
    else $error("interrupt not raised");
  irq_clear_a: assert property ((!sec_drive_irq) [*5] |-> !inta_oe)
    else $error("interrupt held after clear");
  cable_follow_a: assert property ($stable(sec_cable_type_in) [*5] |-> cable_80 == sec_cable_type_in)
    else $error("cable type lost");
  soft_reset_a: assert property (soft_reset |=> !sec_drive_reset_n)
    else $error("soft reset ignored");
endmodule
bind pci_ata_channel_interface pci_ata_channel_interface_properties #(.CMD_BASE(CMD_BASE)) chk (
  .clk_sys, .rst, .frame_n, .irdy_n, .ad_in, .cbe_n, .ad_out, .ad_oe, .par_out, .par_oe,
  .tgt, .tgt_oe, .perr_n_out, .perr_oe, .serr_oe, .inta_oe, .sec_disk_data_oe, .ata_ctl,
  .sec_drive_reset_n, .sec_cable_type_in, .sec_drive_irq, .sec_dma_req, .soft_reset,
  .irq_enable, .dma_enable, .cable_80);
`default_nettype wire

// file: pci_ata_pkg.sv
/*
  shared constants and carrier types for the secondary-channel pci to ata bridge.
  assumes one clock domain (the pci clock) and a synchronous active-high reset.
*/
`default_nettype none
package pci_ata_pkg;

  // pci bus commands as seen on c/be# during the address phase
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // default i/o decode windows: command block (8 bytes), control block (4 bytes)
  localparam logic [31:0] CMD_BASE_DEF = 32'h0000_1000;
  localparam logic [31:0] CTL_BASE_DEF = 32'h0000_1008;

  // identity words, values arbitrary
  localparam logic [15:0] VENDOR_ID_DEF = 16'h1234;
  localparam logic [15:0] DEVICE_ID_DEF = 16'h5678;

  // reset values and synchroniser depth
  localparam logic [31:0] CFG_ZERO     = 32'h0000_0000;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [5:0]  CFG_IDX_ID   = 6'h00;
  localparam int          SYNC_STAGES  = 2;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_DEC    = 3'b001,
    S_STROBE = 3'b010,
    S_RECOV  = 3'b011,
    S_RESP   = 3'b100,
    S_TURN   = 3'b101,
    S_DMA    = 3'b110
  } state_t;

  typedef struct packed {
    logic       sec_cmd_block_select_n;
    logic       sec_ctl_block_select_n;
    logic [2:0] sec_disk_reg_addr;
    logic       sec_read_strobe_n;
    logic       sec_write_strobe_n;
    logic       sec_dma_ack_n;
  } ata_ctl_t;

  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
  } pci_tgt_t;

  localparam ata_ctl_t ATA_IDLE = '{1'b1, 1'b1, 3'b000, 1'b1, 1'b1, 1'b1};
  localparam pci_tgt_t TGT_IDLE = '{1'b1, 1'b1, 1'b1};

endpackage
`default_nettype wire

// file: sync_bits.sv
/*
  two-stage synchroniser for a bundle of independent level inputs.
  assumes each bit is a slowly changing level; buses are only sampled once settled.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_bits #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// file: tb_pci_ata_channel_interface.sv
/* self-checking bench for the pci to ata bridge.
   assumes package, design, checker and drive model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module tb_pci_ata_channel_interface
  import pci_ata_pkg::*;
;
  logic        clk_sys, rst, frame_n, irdy_n, idsel, par_in, bad_par, ad_oe, par_out, par_oe;
  logic        tgt_oe, perr_n_out, perr_oe, serr_oe, inta_oe, sec_disk_data_oe, wr_q;
  logic        sec_drive_reset_n, sec_cable_type_in, sec_drive_irq, sec_drive_ready;
  logic        sec_dma_req, soft_reset, irq_enable, serr_enable, parity_enable, dma_enable;
  logic        dma_to_drive, dma_wvalid, dma_wtaken, dma_rvalid, cable_80, slow, load;
  logic        h, wr, ctl, a2;
  logic [31:0] ad_in, ad_out, a, wd, r;
  logic [15:0] sec_disk_data_in, sec_disk_data_out, dma_wdata, dma_rdata, rd_word;
  logic [15:0] dw [4];
  logic [7:0]  pio_active, pio_recovery;
  logic [3:0]  cbe_n, words, be;
  logic [1:0]  ln;
  pci_tgt_t    tgt;
  ata_ctl_t    ata_ctl, seen_ctl;
  logic [15:0] wq [$];
  logic [15:0] rq [$];
  int          fails, n_compared, n_serr, n_perr, i, j, k;
  integer      seed;

  pci_ata_channel_interface dut (.clk_sys, .rst, .frame_n, .irdy_n, .idsel, .ad_in, .cbe_n,
    .par_in, .ad_out, .ad_oe, .par_out, .par_oe, .tgt, .tgt_oe, .perr_n_out, .perr_oe,
    .serr_oe, .inta_oe, .sec_disk_data_in, .sec_disk_data_out, .sec_disk_data_oe, .ata_ctl,
    .sec_drive_reset_n, .sec_cable_type_in, .sec_drive_irq, .sec_drive_ready, .sec_dma_req,
    .soft_reset, .irq_enable, .serr_enable, .parity_enable, .pio_active, .pio_recovery,
    .dma_enable, .dma_to_drive, .dma_wdata, .dma_wvalid, .dma_wtaken, .dma_rdata, .dma_rvalid,
    .cable_80);
  ata_drive_model drive (.clk_sys, .ata_ctl, .data_out(sec_disk_data_out),
    .data_oe(sec_disk_data_oe), .rd_word, .slow, .load, .words, .data_in(sec_disk_data_in),
    .ready(sec_drive_ready), .dma_req(sec_dma_req));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // master parity trails ad and c/be by one clock
  always @(posedge clk_sys) begin
    par_in <= ^{ad_in, cbe_n} ^ bad_par;
    wr_q <= ata_ctl.sec_write_strobe_n;
    if (serr_oe) n_serr++;
    if (perr_oe && !perr_n_out) n_perr++;
    if (!ata_ctl.sec_read_strobe_n || !ata_ctl.sec_write_strobe_n) seen_ctl <= ata_ctl;
    if (sec_disk_data_oe && wr_q && !ata_ctl.sec_write_strobe_n) wq.push_back(sec_disk_data_out);
    if (dma_rvalid) rq.push_back(dma_rdata);
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [1:0] low_lane(input logic [3:0] b);
    low_lane = !b[0] ? 2'h0 : !b[1] ? 2'h1 : !b[2] ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [31:0] rd_exp(input logic [1:0] l, input logic [15:0] d);
    rd_exp = l[0] ? {4{d[7:0]}} : {d, d};
  endfunction
  function automatic logic [15:0] wr_exp(input logic [1:0] l, input logic [31:0] d);
    wr_exp = l[0] ? {8'h00, d[8*l +: 8]} : d[8*l +: 16];
  endfunction

  task automatic pci(input logic [3:0] cmd, input logic [31:0] ad, input logic [3:0] b,
                     input logic cfg, input logic bp, output logic [31:0] rd, output logic hit);
    int n;
    rd = '0;
    hit = 1'b0;
    @(posedge clk_sys);
    frame_n <= 1'b0;
    ad_in <= ad;
    cbe_n <= cmd;
    idsel <= cfg;
    bad_par <= bp;
    @(posedge clk_sys);
    frame_n <= 1'b1;
    irdy_n <= 1'b0;
    cbe_n <= b;
    ad_in <= wd;
    idsel <= 1'b0;
    // a miss gives up after 8 clocks, a master abort
    for (n = 0; n < (hit ? 800 : 8) && !(hit && !tgt.trdy_n); n++) begin
      @(posedge clk_sys);
      #1;
      if (!tgt.devsel_n && tgt_oe) hit = 1'b1;
    end
    rd = ad_out;
    if (hit) chk("trdy", 0, tgt.trdy_n);
    if (hit) chk("stop", 0, tgt.stop_n);
    @(posedge clk_sys);
    irdy_n <= 1'b1;
    ad_in <= '0;
    cbe_n <= 4'hf;
    bad_par <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  initial begin
    seed = 32'h89e6;
    {rst, frame_n, irdy_n, load} = 4'hf;
    {idsel, bad_par, soft_reset, irq_enable, parity_enable} = 5'h01;
    {dma_enable, dma_to_drive, dma_wvalid, sec_cable_type_in, sec_drive_irq, slow} = 6'h00;
    {ad_in, cbe_n, dma_wdata, rd_word, words, wd} = {32'h0, 4'hf, 16'h0, 16'h0, 4'h0, 32'h0};
    {pio_active, pio_recovery, serr_enable} = {8'h02, 8'h01, 1'b1};
    repeat (3) @(posedge clk_sys);
    chk("drive_reset", 0, sec_drive_reset_n);
    rst <= 1'b0;
    load <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("drive_reset", 1, sec_drive_reset_n);
    pci(CMD_CFG_RD, 32'h0, 4'h0, 1'b1, 1'b0, r, h);
    chk("cfg_id", {DEVICE_ID_DEF, VENDOR_ID_DEF}, r);
    pci(CMD_CFG_RD, 32'h0, 4'h0, 1'b0, 1'b0, r, h);
    chk("cfg_nosel", 0, h);
    pci(CMD_IO_RD, 32'h2000, 4'h0, 1'b0, 1'b0, r, h);
    chk("unmapped", 0, h);
    for (k = 0; k < 24; k++) begin
      wr = (k == 5) | 1'($random(seed));
      ctl = (k % 4 == 3);
      be = 4'($random(seed));
      if (be == 4'hf) be = 4'h7;
      ln = low_lane(be);
      a2 = ctl ? 1'b0 : 1'($random(seed));
      a = (ctl ? CTL_BASE_DEF : CMD_BASE_DEF) | {29'h0, a2, ln};
      wd = $random(seed);
      @(posedge clk_sys);
      rd_word <= 16'($random(seed));
      slow <= 1'($random(seed));
      pio_active <= 8'h02 + 8'($random(seed) & 3);
      pio_recovery <= 8'($random(seed) & 3);
      pci(wr ? CMD_IO_WR : CMD_IO_RD, a, be, 1'b0, k == 5, r, h);
      chk("io_hit", 1, h);
      chk("reg_addr", {ctl | a2, ln}, seen_ctl.sec_disk_reg_addr);
      chk("selects", ctl ? 2'h2 : 2'h1, seen_ctl[7:6]);
      if (wr) chk("wdata", wr_exp(ln, wd), wq.size() ? wq.pop_front() : 16'hxxxx);
      else chk("rdata", rd_exp(ln, rd_word), r);
    end
    chk("serr_count", 1, n_serr);
    chk("perr_count", 1, n_perr);
    chk("strobes_idle", 2'h3, {ata_ctl.sec_read_strobe_n, ata_ctl.sec_write_strobe_n});
    soft_reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("soft_reset", 0, sec_drive_reset_n);
    soft_reset <= 1'b0;
    for (k = 0; k < 2; k++) begin
      sec_cable_type_in <= k[0];
      repeat (6) @(posedge clk_sys);
      chk("cable", k, cable_80);
    end
    for (k = 0; k < 3; k++) begin
      {irq_enable, sec_drive_irq} <= 2'(3 - k);
      repeat (6) @(posedge clk_sys);
      chk("irq", k == 0, inta_oe);
    end
    {dma_to_drive, dma_enable, slow, words, load} <= {3'h7, 4'h4, 1'b1};
    @(posedge clk_sys);
    load <= 1'b0;
    for (j = 0; j < 4; j++) begin
      dw[j] = 16'($random(seed));
      dma_wdata <= dw[j];
      dma_wvalid <= 1'b1;
      i = 0;
      do @(posedge clk_sys); while (!dma_wtaken && ++i < 300);
    end
    dma_wvalid <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk("ack_released", 1, ata_ctl.sec_dma_ack_n);
    for (j = 0; j < 4; j++) chk("dma_wdata", dw[j], wq.size() ? wq.pop_front() : 16'hxxxx);
    {rd_word, dma_to_drive, words, load} <= {16'($random(seed)), 1'b0, 4'h3, 1'b1};
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (120) @(posedge clk_sys);
    chk("dma_rcount", 3, rq.size());
    while (rq.size()) chk("dma_rdata", rd_word, rq.pop_front());
    finish_test();
  end
endmodule
`default_nettype wire
